// *** core/sec_pkg.sv ***
// Purpose: Constants, types and command encodings for the serial EEPROM command core
// Assumes: 100 MHz system clock, serial clock at most 2 MHz from the host
// Notes: Memory is 2048 bytes, seen as 1024 x16 words or 2048 x8 bytes
// Function
// R1 - Frame is start bit one, 2-bit opcode, 10/11-bit address, write data after
// R2 - Without data a frame is 13 bits in x16, 14 bits in x8
// R3 - Opcode 10 reads, 11 erases a location, 01 programs a location with data
// R4 - Opcode 00 uses top address bits: 11 enable, 00 disable, 10 clear, 01 fill
// R5 - Serial input bits are sampled on each rising serial clock edge
// R6 - Data output floats except during read data or ready/busy status
// R7 - Selected after cycle start: output low while busy, high when ready
// R8 - A dummy one while status shows releases the output on falling clock
// R9 - Host sharing one data line sends the dummy one before driving it
// R10 - Program, erase, clear-all, fill-all need program enable high; enable/disable do not
// R11 - Read sends one leading zero, then the addressed word MSB first
// R12 - Outgoing read bits change on the rising serial clock edge
// R13 - Clocking on after a word sends the next address, wrapping to zero
// R14 - Only the first word of a sequential read has the leading zero
// R15 - Self-timed cycle starts on chip select deassertion, no clocks needed
// R16 - Program clears the location itself before storing new data
// R17 - Erase self-times a clear of one location to all ones
// R18 - Every self-timed cycle finishes within 5 ms, then status shows ready
// R19 - Write-enable latch clear at power-up; writes refused until enabled
// R20 - Write disable blocks program and clear; reads always work
// R21 - Clear-all self-times a clear of the whole array to all ones
// R22 - Width select high gives x16, low gives x8 organisation
// R23 - During a self-timed cycle new instructions are ignored, only status shows
package sec_pkg;

   // -------------------------------------------------------------
   // Array and frame geometry
   // -------------------------------------------------------------
   localparam int BYTES = 2048;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam int SREG_W = 29;
   localparam logic [5:0] HDR_LEN_X16 = 6'h0c;
   localparam logic [5:0] HDR_LEN_X8 = 6'h0d;
   localparam logic [5:0] DLEN_X16 = 6'h10;
   localparam logic [5:0] DLEN_X8 = 6'h08;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // -------------------------------------------------------------
   // Opcodes and sub-commands
   // -------------------------------------------------------------
   localparam logic [1:0] OP_SPECIAL = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [1:0] SUB_WDS = 2'h0;
   localparam logic [1:0] SUB_FILL = 2'h1;
   localparam logic [1:0] SUB_CLR = 2'h2;
   localparam logic [1:0] SUB_WEN = 2'h3;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int MCLK_MHZ = 100;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYC = PROG_TIME_US * MCLK_MHZ;
   localparam int MIN_DESEL_NS = 250;
   localparam int MIN_DESEL_CYC = (MIN_DESEL_NS * MCLK_MHZ) / 1000;
   localparam int TMR_W = 24;

   // -------------------------------------------------------------
   // Synchroniser bit positions
   // -------------------------------------------------------------
   localparam int SY_CS = 0;
   localparam int SY_TGL = 1;
   localparam int SY_REL = 2;
   localparam int SY_RACT = 3;
   localparam int SY_RBIT = 4;
   localparam int SY_PE = 5;
   localparam int SY_W = 6;

   typedef enum logic [2:0] {
      K_WRITE = 3'h0,
      K_ERASE = 3'h1,
      K_WEN = 3'h2,
      K_WDS = 3'h3,
      K_CLRALL = 3'h4,
      K_FILL = 3'h5
   } sec_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WALK = 3'b010,
      ST_HOLD = 3'b100
   } sec_state_t;

   typedef struct packed {
      sec_kind_t kind;
      logic wide;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } sec_cmd_t;

endpackage : sec_pkg

// *** core/sec_eeprom_core.sv ***
// Purpose: Serial EEPROM command decoder, read shifter and self-timed write sequencer
// Assumes: Serial clock only runs while chip select is high; chip select low resets the frame decode, status release and read shifter
// Notes: Data output is re-timed on the system clock, so output delay is two to three system cycles
module sec_eeprom_core
   import sec_pkg::*;
#(
   parameter int P_PROG_CYC = PROG_CYC
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic serial_clock_i,
   input wire logic chip_select_i,
   input wire logic serial_data_in_i,
   input wire logic program_enable_pin_i,
   input wire logic word_width_select_i,
   output logic data_out_o,
   output logic data_oe_n_o,
   output logic busy_o,
   output logic write_enable_o
);

   // -------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------
   generate
      if (P_PROG_CYC < BYTES + 1 || P_PROG_CYC >= (1 << TMR_W))
      begin : g_bad_cyc
         $error("P_PROG_CYC out of range");
      end
      if (MIN_DESEL_CYC < 5)
      begin : g_bad_desel
         $error("Deselect time too short for crossing");
      end
   endgenerate

   logic [7:0] mem [BYTES];

   // -------------------------------------------------------------
   // Link side: frame decode on the serial clock
   // -------------------------------------------------------------
   logic sk_rst;
   logic org_s1;
   logic org_s2;
   logic started;
   logic hdr_done;
   logic done;
   logic data_pend;
   logic [5:0] bcnt;
   logic [SREG_W-1:0] sreg;
   logic [SREG_W-1:0] full;
   sec_kind_t kind_q;
   logic [ADDR_W-1:0] addr_q;
   logic [5:0] hdr_len;
   logic [5:0] dlen;
   logic [1:0] dec_op;
   logic [1:0] dec_sub;
   logic [ADDR_W-1:0] dec_addr;
   logic [DATA_W-1:0] dec_data;
   logic needs_data;
   logic at_hdr;
   logic at_data;
   logic cap;
   sec_cmd_t cmd_q;
   logic cmd_tgl;
   logic rel;

   assign sk_rst = rst_i | ~chip_select_i;

   function automatic sec_kind_t kind_of(input logic [1:0] op, input logic [1:0] sub);
      sec_kind_t k;
      k = K_WDS;
      case (op)
         OP_WRITE: k = K_WRITE;
         OP_ERASE: k = K_ERASE;
         default:
         begin
            case (sub)
               SUB_WEN: k = K_WEN;
               SUB_CLR: k = K_CLRALL;
               SUB_FILL: k = K_FILL;
               default: k = K_WDS;
            endcase
         end
      endcase
      return k;
   endfunction : kind_of

   function automatic logic [DATA_W-1:0] word_at(input logic [ADDR_W-1:0] a, input logic wide);
      logic [DATA_W-1:0] w;
      w = {mem[a], 8'h00};
      if (wide)
      begin
         w = {mem[{a[ADDR_W-2:0], 1'b0}], mem[{a[ADDR_W-2:0], 1'b1}]};
      end
      return w;
   endfunction : word_at

   // Width strap crossed into the link clock; not cleared by chip select
   always_ff @(posedge serial_clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         org_s1 <= 1'b1;
         org_s2 <= 1'b1;
      end
      else
      begin
         org_s1 <= word_width_select_i;
         org_s2 <= org_s1;
      end
   end

   always_comb
   begin
      full = {sreg[SREG_W-2:0], serial_data_in_i};
      hdr_len = org_s2 ? HDR_LEN_X16 : HDR_LEN_X8; // R1 R2 R22
      dlen = org_s2 ? DLEN_X16 : DLEN_X8; // R1 R22
      dec_op = org_s2 ? full[11:10] : full[12:11];
      dec_sub = org_s2 ? full[9:8] : full[10:9]; // R4
      dec_addr = org_s2 ? {1'b0, full[9:0]} : full[10:0];
      dec_data = org_s2 ? full[15:0] : {8'h00, full[7:0]};
      needs_data = (dec_op == OP_WRITE) || (dec_op == OP_SPECIAL && dec_sub == SUB_FILL);
      at_hdr = started && !hdr_done && (bcnt + 6'h01 == hdr_len);
      at_data = started && data_pend && (bcnt + 6'h01 == hdr_len + dlen);
      cap = (at_hdr && !needs_data && dec_op != OP_READ) || at_data;
   end

   // Bits sampled on the rising edge, frame cleared by deselect
   always_ff @(posedge serial_clock_i or posedge sk_rst)
   begin
      if (sk_rst)
      begin
         started <= 1'b0;
         hdr_done <= 1'b0;
         done <= 1'b0;
         data_pend <= 1'b0;
         bcnt <= 6'h00;
         sreg <= '0;
         kind_q <= K_WDS;
         addr_q <= '0;
      end
      else if (!started)
      begin
         started <= serial_data_in_i; // R1 R5
      end
      else if (!done)
      begin
         sreg <= full; // R5
         bcnt <= bcnt + 6'h01;
         if (at_hdr)
         begin
            hdr_done <= 1'b1;
            kind_q <= kind_of(dec_op, dec_sub); // R3 R4
            addr_q <= dec_addr;
            data_pend <= needs_data;
            done <= !needs_data;
         end
         if (at_data)
         begin
            data_pend <= 1'b0;
            done <= 1'b1;
         end
      end
   end

   // Finished write-type command, held for the system side
   always_ff @(posedge serial_clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cmd_q <= '{kind: K_WDS, wide: 1'b1, addr: '0, data: '0};
         cmd_tgl <= 1'b0;
      end
      else if (cap)
      begin
         cmd_q.kind <= at_data ? kind_q : kind_of(dec_op, dec_sub);
         cmd_q.wide <= org_s2;
         cmd_q.addr <= at_data ? addr_q : dec_addr;
         cmd_q.data <= at_data ? dec_data : '0;
         cmd_tgl <= ~cmd_tgl;
      end
   end

   // Start bit or dummy one lets go of the status output
   always_ff @(negedge serial_clock_i or posedge sk_rst)
   begin
      if (sk_rst)
      begin
         rel <= 1'b0;
      end
      else
      begin
         rel <= started; // R8 R9
      end
   end

   // -------------------------------------------------------------
   // Link side: read data shifter
   // -------------------------------------------------------------
   logic rd_act;
   logic rd_bit;
   logic [DATA_W-1:0] rd_sh;
   logic [ADDR_W-1:0] rd_addr;
   logic [ADDR_W-1:0] rd_next;
   logic [5:0] rd_cnt;

   assign rd_next = org_s2 ? {1'b0, rd_addr[ADDR_W-2:0] + 10'h001} : rd_addr + 11'h001; // R13

   always_ff @(posedge serial_clock_i or posedge sk_rst)
   begin
      if (sk_rst)
      begin
         rd_act <= 1'b0;
         rd_bit <= 1'b0;
         rd_sh <= '0;
         rd_addr <= '0;
         rd_cnt <= 6'h00;
      end
      else if (at_hdr && dec_op == OP_READ)
      begin
         rd_act <= 1'b1;
         rd_bit <= 1'b0; // R11
         rd_sh <= word_at(dec_addr, org_s2);
         rd_addr <= dec_addr;
         rd_cnt <= dlen;
      end
      else if (rd_act)
      begin
         rd_bit <= rd_sh[DATA_W-1]; // R11 R12
         if (rd_cnt == 6'h01)
         begin
            rd_sh <= word_at(rd_next, org_s2); // R13 R14
            rd_addr <= rd_next;
            rd_cnt <= dlen;
         end
         else
         begin
            rd_sh <= {rd_sh[DATA_W-2:0], 1'b0};
            rd_cnt <= rd_cnt - 6'h01;
         end
      end
   end

   // -------------------------------------------------------------
   // System side: crossings
   // -------------------------------------------------------------
   logic [SY_W-1:0] sy1;
   logic [SY_W-1:0] sy2;
   logic [SY_W-1:0] sy_in;
   logic cs_d;
   logic cs_dd;
   logic seen;

   assign sy_in = {program_enable_pin_i, rd_bit, rd_act, rel, cmd_tgl, chip_select_i};

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sy1 <= '0;
         sy2 <= '0;
         cs_d <= 1'b0;
         cs_dd <= 1'b0;
      end
      else
      begin
         sy1 <= sy_in;
         sy2 <= sy1;
         cs_d <= sy2[SY_CS];
         cs_dd <= cs_d;
      end
   end

   // -------------------------------------------------------------
   // System side: command acceptance
   // -------------------------------------------------------------
   sec_state_t st;
   logic cs_fall;
   logic cs_rise;
   logic accept;
   logic start_go;
   logic frame_busy;
   logic show_status;
   sec_kind_t k;

   assign k = cmd_q.kind;
   assign cs_fall = cs_dd & ~cs_d;
   assign cs_rise = cs_d & ~cs_dd;
   assign accept = cs_fall && (sy2[SY_TGL] != seen) && st == ST_IDLE && !frame_busy; // R15 R23
   assign start_go = accept && k != K_WEN && k != K_WDS && write_enable_o && sy2[SY_PE]; // R10 R19 R20

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         seen <= 1'b0;
         frame_busy <= 1'b0;
      end
      else
      begin
         if (cs_fall)
         begin
            seen <= sy2[SY_TGL];
         end
         if (cs_rise)
         begin
            frame_busy <= (st != ST_IDLE); // R23
         end
         else if (cs_fall)
         begin
            frame_busy <= 1'b0;
         end
      end
   end

   // Write-enable latch, cleared at power-up
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         write_enable_o <= 1'b0; // R19
      end
      else if (accept && k == K_WEN)
      begin
         write_enable_o <= 1'b1; // R19
      end
      else if (accept && k == K_WDS)
      begin
         write_enable_o <= 1'b0; // R20
      end
   end

   // -------------------------------------------------------------
   // System side: self-timed cycle
   // -------------------------------------------------------------
   logic [ADDR_W-1:0] widx;
   logic [ADDR_W-1:0] wlast;
   logic [TMR_W-1:0] tmr;
   logic [7:0] wbyte;
   logic w_ones;

   assign w_ones = (k == K_ERASE) || (k == K_CLRALL);
   assign wbyte = w_ones ? ERASED_BYTE : (cmd_q.wide && !widx[0]) ? cmd_q.data[15:8] : cmd_q.data[7:0]; // R16 R17 R21

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st <= ST_IDLE;
         widx <= '0;
         wlast <= '0;
         tmr <= '0;
         busy_o <= 1'b0;
      end
      else
      begin
         busy_o <= (st != ST_IDLE);
         case (st)
            ST_IDLE:
            begin
               if (start_go)
               begin
                  st <= ST_WALK; // R15
                  tmr <= TMR_W'(P_PROG_CYC - 1); // R18
                  if (k == K_CLRALL || k == K_FILL)
                  begin
                     widx <= '0; // R21
                     wlast <= ADDR_W'(BYTES - 1);
                  end
                  else if (cmd_q.wide)
                  begin
                     widx <= {cmd_q.addr[ADDR_W-2:0], 1'b0};
                     wlast <= {cmd_q.addr[ADDR_W-2:0], 1'b1};
                  end
                  else
                  begin
                     widx <= cmd_q.addr;
                     wlast <= cmd_q.addr;
                  end
               end
            end
            ST_WALK:
            begin
               tmr <= tmr - TMR_W'(1);
               widx <= widx + 11'h001;
               if (widx == wlast)
               begin
                  st <= ST_HOLD;
               end
            end
            ST_HOLD:
            begin
               if (tmr == '0)
               begin
                  st <= ST_IDLE; // R18
               end
               else
               begin
                  tmr <= tmr - TMR_W'(1);
               end
            end
            default:
            begin
               st <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (st == ST_WALK)
      begin
         mem[widx] <= wbyte; // R16 R17 R21
      end
   end

   // -------------------------------------------------------------
   // System side: data output pin
   // -------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         show_status <= 1'b0;
      end
      else if (start_go)
      begin
         show_status <= 1'b1; // R7
      end
      else if ((sy2[SY_CS] && sy2[SY_REL]) || (cs_fall && st == ST_IDLE))
      begin
         show_status <= 1'b0; // R8
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         data_out_o <= 1'b0;
         data_oe_n_o <= 1'b1;
      end
      else if (sy2[SY_CS] && show_status && !sy2[SY_REL])
      begin
         data_oe_n_o <= 1'b0;
         data_out_o <= (st == ST_IDLE); // R7
      end
      else if (sy2[SY_CS] && sy2[SY_RACT] && st == ST_IDLE)
      begin
         data_oe_n_o <= 1'b0; // R11 R20 R23
         data_out_o <= sy2[SY_RBIT];
      end
      else
      begin
         data_oe_n_o <= 1'b1; // R6
         data_out_o <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   logic [TMR_W-1:0] busy_age;

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         busy_age <= '0;
      end
      else
      begin
         busy_age <= (st == ST_IDLE) ? '0 : busy_age + TMR_W'(1);
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   AST_HIZ_DESELECTED: assert property (!sy2[SY_CS] |=> data_oe_n_o) // R6
      else $error("Data output driven while deselected");
   AST_BUSY_LOW: assert property ((sy2[SY_CS] && show_status && !sy2[SY_REL] && st != ST_IDLE)
      |=> (!data_oe_n_o && !data_out_o)) // R7
      else $error("Busy not shown low");
   AST_READY_HIGH: assert property ((sy2[SY_CS] && show_status && !sy2[SY_REL] && st == ST_IDLE)
      |=> (!data_oe_n_o && data_out_o)) // R7
      else $error("Ready not shown high");
   AST_RELEASE: assert property ((sy2[SY_CS] && sy2[SY_REL] && !sy2[SY_RACT]) |=> data_oe_n_o) // R8
      else $error("Output not released after dummy one");
   AST_PE_GATE: assert property ((st == ST_IDLE && !sy2[SY_PE]) |=> st == ST_IDLE) // R10
      else $error("Cycle started with program enable low");
   AST_WEN_GATE: assert property ((st == ST_IDLE && !write_enable_o) |=> st == ST_IDLE) // R19
      else $error("Cycle started with write enable clear");
   AST_WDS_CLEARS: assert property ((accept && k == K_WDS) |=> (!write_enable_o ##1 st == ST_IDLE)) // R20
      else $error("Write disable not effective");
   AST_CYCLE_BOUND: assert property (busy_age <= TMR_W'(P_PROG_CYC)) // R18
      else $error("Self-timed cycle too long");
   AST_IGNORE_BUSY: assert property ((cs_fall && frame_busy) |=> $stable(write_enable_o)) // R23
      else $error("Instruction taken during busy frame");
   AST_ERASE_ONES: assert property ((st == ST_WALK && w_ones) |=> mem[$past(widx)] == ERASED_BYTE) // R17
      else $error("Clear writes a value other than ones");
   AST_START_WALK: assert property (start_go |=> (st == ST_WALK && busy_age == '0)) // R15
      else $error("Cycle did not start on deselect");

   CV_PROGRAM: cover property (start_go && k == K_WRITE);
   CV_CLEAR_ALL: cover property (start_go && k == K_CLRALL);
   CV_READ_OUT: cover property (!data_oe_n_o && sy2[SY_RACT] && !show_status);
   CV_STATUS_RELEASE: cover property (show_status ##1 !show_status);

endmodule : sec_eeprom_core

// *** testbench/sec_host.sv ***
// Purpose: Host model driving the serial frame pins
// Assumes: Fast clock for commands, slow clock for read data
// Notes: Serial clock idles low outside frames
module sec_host
(
   output logic sk_o,
   output logic cs_o,
   output logic di_o,
   input wire logic do_i,
   input wire logic oe_n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   wire pin = oe_n_i ? 1'bz : do_i;
   initial
   begin
      sk_o = 1'h0;
      cs_o = 1'h0;
      di_o = 1'h0;
   end
   task automatic shift(input logic [39:0] v, input int n, input int h);
      for (int i = n - 1; i >= 0; i--)
      begin
         di_o = v[i];
         #(h);
         sk_o = 1'h1;
         #(h);
         sk_o = 1'h0;
      end
   endtask : shift
   // Sample just before each rise, data moves after it
   task automatic grab(input int n, output logic [39:0] q);
      q = '0;
      repeat (n)
      begin
         #60;
         q = {q[38:0], pin};
         sk_o = 1'h1;
         #60;
         sk_o = 1'h0;
      end
   endtask : grab
   task automatic sel();
      cs_o = 1'h1;
      #60;
   endtask : sel
   task automatic desel();
      cs_o = 1'h0;
      di_o = ~di_o;
      #300;
   endtask : desel
endmodule : sec_host

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the serial EEPROM core
// Assumes: Shortened program cycle of 3000 system clocks
// Notes: Read bits are clocked slowly, see host model
module testbench
   import sec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 3000;
   logic mclk_i, rst_i, pe, ws, sk, cs, di, dout, oen, busy, we;
   int fail_count, cmp_count;
   int nbusy, nb0;
   logic [39:0] q;
   logic [15:0] d, e;
   logic [10:0] a;
   sec_eeprom_core #(.P_PROG_CYC(PC)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
      .serial_clock_i(sk), .chip_select_i(cs), .serial_data_in_i(di),
      .program_enable_pin_i(pe), .word_width_select_i(ws), .data_out_o(dout),
      .data_oe_n_o(oen), .busy_o(busy), .write_enable_o(we));
   sec_host host (.sk_o(sk), .cs_o(cs), .di_o(di), .do_i(dout), .oe_n_i(oen));
   // Busy cycles counted on the system clock
   always @(posedge mclk_i)
   begin
      if (busy === 1'h1)
         nbusy <= nbusy + 1;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [39:0] x, input logic [39:0] g);
      cmp_count++;
      if (g !== x)
      begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, x, g);
      end
   endtask : chk
   task automatic cmd(input logic [1:0] op, input logic [10:0] ad, input logic [15:0] dt);
      logic [39:0] v;
      int n;
      logic [1:0] s;
      s = ad[1:0];
      if (op == OP_SPECIAL)
         ad = ws ? {1'h0, s, 8'h0} : {s, 9'h0};
      v = {38'h1, op};
      n = ws ? 13 : 14;
      v = ws ? {v[29:0], ad[9:0]} : {v[28:0], ad};
      if (op == OP_WRITE || (op == OP_SPECIAL && s == SUB_FILL))
      begin
         v = ws ? {v[23:0], dt} : {v[31:0], dt[7:0]};
         n += ws ? 16 : 8;
      end
      host.sel();
      host.shift(v, n, 6);
      host.desel();
   endtask : cmd
   task automatic rd(input logic [10:0] ad, input int n);
      host.sel();
      host.shift(ws ? {27'h0, 3'h6, ad[9:0]} : {26'h0, 3'h6, ad}, ws ? 13 : 14, 6);
      host.grab(n, q);
      host.desel();
   endtask : rd
   task automatic run();
      int c;
      c = 0;
      while (busy !== 1'h1 && c < 20)
      begin
         @(negedge mclk_i);
         c++;
      end
      host.sel();
      chk("status busy", 1'h0, host.pin);
      c = 6;
      while (busy === 1'h1 && c < PC + 10)
      begin
         @(negedge mclk_i);
         c++;
      end
      chk("busy length", PC, nbusy - nb0);
      nb0 = nbusy;
      #100;
      chk("status ready", 1'h1, host.pin);
      host.shift(40'h1, 1, 60);
      #50;
      chk("released", 1'hz, host.pin);
      host.desel();
   endtask : run
   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial
   begin
      mclk_i = 1'h0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial
   begin
      #800us;
      fail_count++;
      close_out();
   end
   initial
   begin
      rst_i = 1'h1;
      pe = 1'h1;
      ws = 1'h1;
      fail_count = 0;
      cmp_count = 0;
      repeat (20) @(negedge mclk_i);
      rst_i = 1'h0;
      void'($urandom(32'hb767));
      chk("we reset", 1'h0, we);
      chk("oe_n reset", 1'h1, oen);
      a = 11'($urandom_range(1022, 1));
      d = 16'($urandom);
      e = 16'($urandom);
      cmd(OP_WRITE, a, d);
      chk("busy locked", 1'h0, busy);
      cmd(OP_SPECIAL, SUB_WEN, 16'h0);
      chk("we set", 1'h1, we);
      @(negedge mclk_i);
      pe = 1'h0;
      cmd(OP_WRITE, a, d);
      chk("busy no pe", 1'h0, busy);
      @(negedge mclk_i);
      pe = 1'h1;
      cmd(OP_WRITE, a, d);
      run();
      rd(a, 17);
      chk("read", {1'h0, d}, q);
      cmd(OP_ERASE, a, 16'h0);
      run();
      rd(a, 17);
      chk("erased", 40'h0ffff, q);
      cmd(OP_WRITE, 11'h0, e);
      run();
      cmd(OP_WRITE, 11'h3ff, d);
      run();
      rd(11'h3ff, 33);
      chk("wrap", {1'h0, d, e}, q);
      cmd(OP_SPECIAL, SUB_WDS, 16'h0);
      chk("we clear", 1'h0, we);
      cmd(OP_ERASE, 11'h0, 16'h0);
      chk("busy disabled", 1'h0, busy);
      rd(11'h0, 17);
      chk("read disabled", {1'h0, e}, q);
      cmd(OP_SPECIAL, SUB_WEN, 16'h0);
      @(negedge mclk_i);
      ws = 1'h0;
      a = 11'($urandom_range(2047, 1));
      cmd(OP_WRITE, a, d);
      run();
      rd(a, 9);
      chk("byte read", {1'h0, d[7:0]}, q);
      cmd(OP_SPECIAL, SUB_CLR, 16'h0);
      run();
      rd(a - 11'h1, 9);
      chk("clear all", 40'h0ff, q);
      cmd(OP_SPECIAL, SUB_FILL, e);
      run();
      rd(a, 9);
      chk("fill all", {1'h0, e[7:0]}, q);
      close_out();
   end
endmodule : testbench
